/* File: pkg/ocs_consts.vh */
`ifndef OCS_CONSTS_VH
`define OCS_CONSTS_VH
// ------------------------------------------------------------
// register map (byte addresses, one word each)
// ------------------------------------------------------------
`define OCS_REG_LCFG      8'h00
`define OCS_REG_LDELAY    8'h04
`define OCS_REG_LHOLD     8'h08
`define OCS_REG_LSTAT     8'h0C
`define OCS_REG_CH0_LVL   8'h10
`define OCS_REG_CH0_PCT   8'h14
`define OCS_REG_CH0_LIM   8'h18
`define OCS_REG_CH0_VAL   8'h1C
`define OCS_CH_STRIDE     8'h10
// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define OCS_SRC_LSB       0
`define OCS_SRC_MSB       3
`define OCS_ACTLOW_BIT    8
`define OCS_EN_BIT        9
`define OCS_BIP_BIT       16
// ------------------------------------------------------------
// source codes
// ------------------------------------------------------------
`define OCS_SRC_NONE      4'h0
`define OCS_SRC_NOFAULT   4'h1
`define OCS_SRC_LINE      4'hC
`define OCS_SRC_OUTC      4'hD
`define OCS_SRC_PRECH     4'hE
`define OCS_SRC_DAMPER    4'hF
// ------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------
`define OCS_DELAY_MAX_MS  16'd60000
`define OCS_HOLD_MAX_MS   16'd9999
`define OCS_PCT_LO_RST    8'd0
`define OCS_PCT_HI_RST    8'd100
`define OCS_PCT_FULL      8'd100
`define OCS_LVL_MIN_RST   16'h0000
`define OCS_LVL_MAX_RST   16'hFFFF
`define OCS_LIM_LO_RST    16'h8000
`define OCS_LIM_HI_RST    16'h7FFF
`define OCS_CLK_HZ        100000000
`define OCS_TICK_HZ       1000
`define OCS_TICK_CYC      (`OCS_CLK_HZ / `OCS_TICK_HZ)
`endif

/* File: core/ocs_logic_out.v */
`timescale 1ns/100ps
`include "ocs_consts.vh"
module ocs_logic_out (
  input  wire        ref_clk,
  input  wire        reset_n,
  input  wire        msTick,
  input  wire        info,
  input  wire [15:0] delayMs,
  input  wire [15:0] holdMs,
  input  wire        activeLowPolarity,
  output wire        logicOut,
  output wire        infoActive
);
  // ------------------------------------------------------------
  // delay before asserting, hold before releasing
  // ------------------------------------------------------------
  reg        state_q;
  reg        info_q;
  reg [15:0] cnt_q;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= 1'b0;
      info_q  <= 1'b0;
      cnt_q   <= 16'h0000;
    end else begin
      info_q <= info;
      if (info != info_q) begin
        cnt_q <= 16'h0000;
      end else if (info != state_q) begin
        // an interval ends only on the tick after its last full millisecond,
        // so the partial first tick never shortens it
        if ((info && (delayMs == 16'h0000 || cnt_q > delayMs)) ||
            (!info && (holdMs == 16'h0000 || cnt_q > holdMs))) begin
          state_q <= info;
          cnt_q   <= 16'h0000;
        end else if (msTick) begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  end
  assign infoActive = state_q;
  assign logicOut   = state_q ^ activeLowPolarity;
endmodule

/* File: core/ocs_scaler.v */
`timescale 1ns/100ps
`include "ocs_consts.vh"
module ocs_scaler (
  input  wire               ref_clk,
  input  wire               reset_n,
  input  wire signed [15:0] quantity,
  input  wire signed [15:0] limLo,
  input  wire signed [15:0] limHi,
  input  wire        [7:0]  scaleLowerPct,
  input  wire        [7:0]  scaleUpperPct,
  input  wire        [15:0] outputLevelMin,
  input  wire        [15:0] outputLevelMax,
  input  wire               bipolar,
  output reg         [15:0] level_q
);
  // ------------------------------------------------------------
  // scaled limits and linear transfer
  // ------------------------------------------------------------
  wire signed [17:0] span  = limHi - limLo;
  wire signed [27:0] offLo = span * $signed({1'b0, scaleLowerPct});
  wire signed [27:0] offHi = span * $signed({1'b0, scaleUpperPct});
  wire signed [27:0] divLo = offLo / 28'sd100;
  wire signed [27:0] divHi = offHi / 28'sd100;
  wire signed [17:0] lo    = limLo + $signed(divLo[17:0]);
  wire signed [17:0] hi    = limLo + $signed(divHi[17:0]);
  wire signed [17:0] mid   = lo + ((hi - lo) >>> 1);
  // bipolar maps mid..hi onto min..max; below mid is mirrored symmetrically
  wire signed [17:0] base  = bipolar ? mid : lo;
  wire signed [17:0] den0  = hi - base;
  wire signed [17:0] q     = quantity;
  wire signed [17:0] dq0   = q - base;
  wire signed [17:0] dq1   = (bipolar && dq0 < 0) ? -dq0 : dq0;
  wire signed [17:0] dq    = dq1 < 0 ? 18'sd0 : (dq1 > den0 ? den0 : dq1);
  wire signed [17:0] den   = den0 <= 0 ? 18'sd1 : den0;
  // inverted transfer comes free: a negative out span is allowed
  wire signed [17:0] oSpan = $signed({2'b00, outputLevelMax}) - $signed({2'b00, outputLevelMin});
  wire signed [35:0] prod  = oSpan * dq;
  wire signed [35:0] quo   = prod / den;
  wire signed [17:0] res   = $signed({2'b00, outputLevelMin}) + quo[17:0];
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= 16'h0000;
    end else begin
      level_q <= res[15:0];
    end
  end
endmodule

/* File: core/ocs_output_cond.v */
`timescale 1ns/100ps
`include "ocs_consts.vh"
module ocs_output_cond #(
  parameter NCH     = 3,
  parameter TICKCYC = `OCS_TICK_CYC
) (
  input  wire            ref_clk,
  input  wire            reset_n,
  input  wire            wb_cyc_i,
  input  wire            wb_stb_i,
  input  wire            wb_we_i,
  input  wire [7:0]      wb_adr_i,
  input  wire [3:0]      wb_sel_i,
  input  wire [31:0]     wb_dat_i,
  output reg  [31:0]     wb_dat_o,
  output reg             wb_ack_o,
  output wire            wb_err_o,
  input  wire [15:0]     infoSources,
  input  wire [NCH*16-1:0] quantities,
  output wire [NCH*16-1:0] analogLevels,
  output wire            logicOutOnAnalog
);
  // ------------------------------------------------------------
  // millisecond timebase
  // ------------------------------------------------------------
  reg [16:0] divCnt_q;
  reg        msTick_q;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_q <= 17'h00000;
      msTick_q <= 1'b0;
    end else begin
      msTick_q <= (divCnt_q == TICKCYC - 1);
      if (divCnt_q == TICKCYC - 1) begin
        divCnt_q <= 17'h00000;
      end else begin
        divCnt_q <= divCnt_q + 17'h00001;
      end
    end
  end
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [3:0]  src_q;
  reg        actLow_q;
  reg        logicEn_q;
  reg [15:0] delay_q;
  reg [15:0] hold_q;
  reg [15:0] lvlMin_q [0:NCH-1];
  reg [15:0] lvlMax_q [0:NCH-1];
  reg [7:0]  pctLo_q  [0:NCH-1];
  reg [7:0]  pctHi_q  [0:NCH-1];
  reg        bip_q    [0:NCH-1];
  reg [15:0] limLo_q  [0:NCH-1];
  reg [15:0] limHi_q  [0:NCH-1];
  wire       fixedDelay = (src_q == `OCS_SRC_NOFAULT) || (src_q == `OCS_SRC_OUTC) ||
                          (src_q == `OCS_SRC_PRECH) || (src_q == `OCS_SRC_LINE);
  wire       fixedHold  = (src_q == `OCS_SRC_NOFAULT) || (src_q == `OCS_SRC_PRECH) ||
                          (src_q == `OCS_SRC_LINE);
  wire       req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire [1:0] chSel      = wb_adr_i[5:4] - 2'd1;
  wire       chHit      = (wb_adr_i[7:6] == 2'b00) && (wb_adr_i[5:4] != 2'b00) &&
                          ({30'd0, chSel} < NCH);
  wire       mapped     = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i[7:4] == 4'h0 || chHit);
  // unmapped addresses answer with err, never ack, so software sees the miss
  assign wb_err_o = req && !mapped;
  integer i;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o  <= 1'b0;
      src_q     <= `OCS_SRC_NONE;
      actLow_q  <= 1'b0;
      logicEn_q <= 1'b0;
      delay_q   <= 16'h0000;
      hold_q    <= 16'h0000;
      for (i = 0; i < NCH; i = i + 1) begin
        lvlMin_q[i] <= `OCS_LVL_MIN_RST;
        lvlMax_q[i] <= `OCS_LVL_MAX_RST;
        pctLo_q[i]  <= `OCS_PCT_LO_RST;
        pctHi_q[i]  <= `OCS_PCT_HI_RST;
        bip_q[i]    <= 1'b0;
        limLo_q[i]  <= `OCS_LIM_LO_RST;
        limHi_q[i]  <= `OCS_LIM_HI_RST;
      end
    end else begin
      wb_ack_o <= req && mapped;
      if (req && mapped && wb_we_i) begin
        if (wb_adr_i == `OCS_REG_LCFG) begin
          if (wb_sel_i[0]) begin
            src_q <= wb_dat_i[`OCS_SRC_MSB:`OCS_SRC_LSB];
          end
          if (wb_sel_i[1]) begin
            actLow_q  <= wb_dat_i[`OCS_ACTLOW_BIT];
            logicEn_q <= wb_dat_i[`OCS_EN_BIT];
          end
        end
        if (wb_adr_i == `OCS_REG_LDELAY) begin
          if (wb_sel_i[0]) delay_q[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) delay_q[15:8] <= wb_dat_i[15:8];
        end
        if (wb_adr_i == `OCS_REG_LHOLD) begin
          if (wb_sel_i[0]) hold_q[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) hold_q[15:8] <= wb_dat_i[15:8];
        end
        if (chHit) begin
          case (wb_adr_i[3:0])
            4'h0: begin
              if (wb_sel_i[0]) lvlMin_q[chSel][7:0]  <= wb_dat_i[7:0];
              if (wb_sel_i[1]) lvlMin_q[chSel][15:8] <= wb_dat_i[15:8];
              if (wb_sel_i[2]) lvlMax_q[chSel][7:0]  <= wb_dat_i[23:16];
              if (wb_sel_i[3]) lvlMax_q[chSel][15:8] <= wb_dat_i[31:24];
            end
            4'h4: begin
              if (wb_sel_i[0]) pctLo_q[chSel] <= wb_dat_i[7:0];
              if (wb_sel_i[1]) pctHi_q[chSel] <= wb_dat_i[15:8];
              // only the second and third outputs offer bipolar mode
              if (wb_sel_i[2]) bip_q[chSel] <= wb_dat_i[`OCS_BIP_BIT] && (chSel != 2'd0);
            end
            4'h8: begin
              if (wb_sel_i[0]) limLo_q[chSel][7:0]  <= wb_dat_i[7:0];
              if (wb_sel_i[1]) limLo_q[chSel][15:8] <= wb_dat_i[15:8];
              if (wb_sel_i[2]) limHi_q[chSel][7:0]  <= wb_dat_i[23:16];
              if (wb_sel_i[3]) limHi_q[chSel][15:8] <= wb_dat_i[31:24];
            end
            default: begin
            end
          endcase
        end
      end
    end
  end
  // ------------------------------------------------------------
  // effective settings
  // ------------------------------------------------------------
  wire [15:0] delayClip = delay_q > `OCS_DELAY_MAX_MS ? `OCS_DELAY_MAX_MS : delay_q;
  wire [15:0] holdClip  = hold_q > `OCS_HOLD_MAX_MS ? `OCS_HOLD_MAX_MS : hold_q;
  wire [15:0] delayEff  = fixedDelay ? 16'h0000 : delayClip;
  wire [15:0] holdEff   = fixedHold ? 16'h0000 : holdClip;
  wire        actLowEff = fixedHold ? 1'b0 : actLow_q;
  wire        info      = (src_q == `OCS_SRC_NONE) ? 1'b0 : infoSources[src_q];
  wire        infoActive;
  ocs_logic_out uLogic (
    .ref_clk           (ref_clk),
    .reset_n           (reset_n),
    .msTick            (msTick_q),
    .info              (info),
    .delayMs           (delayEff),
    .holdMs            (holdEff),
    .activeLowPolarity (actLowEff),
    .logicOut          (logicOutOnAnalog),
    .infoActive        (infoActive)
  );
  // ------------------------------------------------------------
  // analog scaling per output
  // ------------------------------------------------------------
  wire [NCH*16-1:0] scaled;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gCh
      ocs_scaler uScale (
        .ref_clk        (ref_clk),
        .reset_n        (reset_n),
        .quantity       (quantities[g*16 +: 16]),
        .limLo          (limLo_q[g]),
        .limHi          (limHi_q[g]),
        .scaleLowerPct  (pctLo_q[g]),
        .scaleUpperPct  (pctHi_q[g]),
        .outputLevelMin (lvlMin_q[g]),
        .outputLevelMax (lvlMax_q[g]),
        .bipolar        (bip_q[g]),
        .level_q        (scaled[g*16 +: 16])
      );
      if (g == 0) begin : gFirst
        reg [15:0] lvl_q;
        always @(posedge ref_clk or negedge reset_n) begin
          if (!reset_n) begin
            lvl_q <= 16'h0000;
          end else if (logicEn_q) begin
            lvl_q <= logicOutOnAnalog ? lvlMax_q[0] : lvlMin_q[0];
          end else begin
            lvl_q <= scaled[15:0];
          end
        end
        assign analogLevels[15:0] = lvl_q;
      end else begin : gRest
        assign analogLevels[g*16 +: 16] = scaled[g*16 +: 16];
      end
    end
  endgenerate
  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (req && mapped) begin
      wb_dat_o <= 32'h00000000;
      if (wb_adr_i == `OCS_REG_LCFG)   wb_dat_o <= {22'd0, logicEn_q, actLowEff, 4'd0, src_q};
      if (wb_adr_i == `OCS_REG_LDELAY) wb_dat_o <= {16'd0, delayEff};
      if (wb_adr_i == `OCS_REG_LHOLD)  wb_dat_o <= {16'd0, holdEff};
      if (wb_adr_i == `OCS_REG_LSTAT)  wb_dat_o <= {29'd0, info, infoActive, logicOutOnAnalog};
      if (chHit) begin
        case (wb_adr_i[3:0])
          4'h0:    wb_dat_o <= {lvlMax_q[chSel], lvlMin_q[chSel]};
          4'h4:    wb_dat_o <= {15'd0, bip_q[chSel], pctHi_q[chSel], pctLo_q[chSel]};
          4'h8:    wb_dat_o <= {limHi_q[chSel], limLo_q[chSel]};
          4'hC:    wb_dat_o <= {16'd0, analogLevels[chSel*16 +: 16]};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

/* File: tb/ocs_output_cond_properties.sv */
`timescale 1ns/100ps
// ----------------------------------------
// bus and logic-mode checks
// ----------------------------------------
module ocs_output_cond_checker #(
  parameter NCH = 3
) (
  input wire              ref_clk,
  input wire              reset_n,
  input wire              wb_cyc_i,
  input wire              wb_stb_i,
  input wire              wb_we_i,
  input wire [7:0]        wb_adr_i,
  input wire [3:0]        wb_sel_i,
  input wire [31:0]       wb_dat_i,
  input wire [31:0]       wb_dat_o,
  input wire              wb_ack_o,
  input wire              wb_err_o,
  input wire [NCH*16-1:0] analogLevels,
  input wire              logicOutOnAnalog
);
  localparam [7:0] MAPEND = 8'h10 + 8'h10 * NCH;
  logic        logicEn_q;
  logic [31:0] lvl_q;
  logic        req;
  // shadows follow acked full-word writes only; byte writes are not tracked
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      logicEn_q <= 1'h0;
      lvl_q     <= 32'hFFFF0000;
    end else if (wb_ack_o && wb_we_i && wb_sel_i == 4'hF) begin
      if (wb_adr_i == 8'h00) begin
        logicEn_q <= wb_dat_i[9];
      end
      if (wb_adr_i == 8'h10) begin
        lvl_q <= wb_dat_i;
      end
    end
  end
  assign req = wb_cyc_i && wb_stb_i;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  ack_one_cycle_a: assert property (req && !wb_ack_o && !wb_err_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(req && !wb_err_o))
    else $error("ack without request");
  err_req_a: assert property (wb_err_o |-> req)
    else $error("err without request");
  err_ack_excl_a: assert property (!(wb_err_o && wb_ack_o))
    else $error("err with ack");
  unmapped_err_a: assert property (req && (wb_adr_i[1:0] != 2'h0 || wb_adr_i >= MAPEND)
    |-> wb_err_o) else $error("unmapped not refused");
  mapped_ok_a: assert property (req && wb_adr_i[1:0] == 2'h0 && wb_adr_i < MAPEND
    |-> !wb_err_o) else $error("mapped refused");
  rdata_hold_a: assert property (wb_ack_o && !wb_we_i |=> $stable(wb_dat_o) [*2])
    else $error("read data moved");
  logic_level_a: assert property (
    logicEn_q && $past(logicEn_q, 3) && !wb_ack_o && !$past(wb_ack_o)
    && !$past(wb_ack_o, 2) && !$past(wb_ack_o, 3) && $stable(logicOutOnAnalog)
    && $past(logicOutOnAnalog, 2) == logicOutOnAnalog
    && $past(logicOutOnAnalog, 3) == logicOutOnAnalog
    |-> analogLevels[15:0] == (logicOutOnAnalog ? lvl_q[31:16] : lvl_q[15:0]))
    else $error("logic level wrong");
  cover property (wb_err_o);
  cover property (wb_ack_o && wb_we_i);
  cover property (logicEn_q && logicOutOnAnalog);
  cover property (logicEn_q && $fell(logicOutOnAnalog));
endmodule
bind ocs_output_cond ocs_output_cond_checker #(.NCH(NCH)) chk (.ref_clk, .reset_n,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .wb_err_o, .analogLevels, .logicOutOnAnalog);

/* File: tb/ocs_receiver_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// receiving logic input on the first output
// ----------------------------------------
module ocs_receiver_model (
  input  wire        ref_clk,
  input  wire [15:0] level,
  output logic       seenState
);
  // mid-scale threshold, as a logic input reading an analog level would
  always @(posedge ref_clk) begin
    seenState <= level[15];
  end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
`include "ocs_consts.vh"
module tb_top;
  logic        ref_clk;
  logic        reset_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] dout;
  logic [31:0] rdat;
  logic        ack;
  logic        err;
  logic        errS;
  logic [15:0] info;
  logic [47:0] qty;
  logic [47:0] lvls;
  logic        lout;
  logic        seenState;
  int          mismatches;
  int          compares;
  int          n;
  ocs_output_cond #(.NCH(3), .TICKCYC(10)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack), .wb_err_o(err),
    .infoSources(info), .quantities(qty), .analogLevels(lvls), .logicOutOnAnalog(lout));
  ocs_receiver_model RX (.ref_clk(ref_clk), .level(lvls[15:0]), .seenState(seenState));
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge ref_clk); while (!ack && !err);
    rdat = dout;
    errS = err;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk(rdat, e);
  endtask
  // bounded wait; the count of edges waited comes back in n
  task automatic waitLout(input logic v);
    n = 0;
    while (lout !== v && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic inRange(input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  task automatic settle(input logic [15:0] q, input logic [15:0] e);
    qty <= {16'h0, q, 16'h0};
    repeat (4) @(posedge ref_clk);
    chk({16'h0, lvls[31:16]}, {16'h0, e});
  endtask
  task automatic t_reset;
    rd(`OCS_REG_LCFG, 32'h0);
    rd(`OCS_REG_LDELAY, 32'h0);
    rd(`OCS_REG_LHOLD, 32'h0);
    rd(`OCS_REG_CH0_PCT, 32'h00006400);
    rd(`OCS_REG_CH0_LVL, 32'hFFFF0000);
    xfer(1'h0, 8'h40, 32'h0);
    chk({31'h0, errS}, 32'h1);
    xfer(1'h1, 8'h06, 32'h0);
    chk({31'h0, errS}, 32'h1);
  endtask
  task automatic t_timing;
    wr(8'h00, 32'h00000202);
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h2);
    info <= 16'h0004;
    repeat (20) @(posedge ref_clk);
    info <= 16'h0000;
    repeat (2) @(posedge ref_clk);
    info <= 16'h0004;
    waitLout(1'h1);
    inRange(30, 48);
    repeat (4) @(posedge ref_clk);
    chk({16'h0, lvls[15:0]}, 32'h0000FFFF);
    chk({31'h0, seenState}, 32'h1);
    info <= 16'h0000;
    waitLout(1'h0);
    inRange(20, 38);
    repeat (4) @(posedge ref_clk);
    chk({16'h0, lvls[15:0]}, 32'h0);
  endtask
  task automatic t_polarity;
    wr(8'h00, 32'h00000302);
    repeat (6) @(posedge ref_clk);
    chk({31'h0, lout}, 32'h1);
    info <= 16'h0004;
    waitLout(1'h0);
    inRange(30, 48);
  endtask
  task automatic t_forced;
    logic [3:0] src [5] = '{4'h1, 4'hC, 4'hD, 4'hE, 4'hF};
    logic [4:0] m = 5'h14;
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, {22'h0, 2'h3, 4'h0, src[i]});
      rd(8'h00, {22'h0, 1'h1, m[i], 4'h0, src[i]});
      rd(8'h04, (m[i] && i == 4) ? 32'h3 : 32'h0);
      rd(8'h08, m[i] ? 32'h2 : 32'h0);
    end
    wr(8'h00, 32'h00000201);
    info <= 16'h0002;
    waitLout(1'h1);
    inRange(1, 8);
    rd(`OCS_REG_LSTAT, 32'h00000007);
    info <= 16'h0000;
    waitLout(1'h0);
    inRange(1, 8);
    wr(8'h00, 32'h00000202);
    wr(8'h04, 32'h0000FFFF);
    rd(8'h04, 32'h0000EA60);
    wr(8'h08, 32'h0000FFFF);
    rd(8'h08, 32'h0000270F);
  endtask
  task automatic t_scale;
    wr(8'h00, 32'h00000002);
    rd(8'h1C, 32'h00008000);
    wr(8'h28, 32'h04B000C8);
    wr(8'h24, 32'h00003C0A);
    wr(8'h20, 32'h03E80000);
    settle(16'h0190, 16'h00C8);
    settle(16'h0320, 16'h03E8);
    wr(8'h20, 32'h000003E8);
    settle(16'h0190, 16'h0320);
    wr(8'h24, 32'h00016400);
    wr(8'h28, 32'h03E8FC18);
    wr(8'h20, 32'h03E80000);
    settle(16'hFE0C, 16'h01F4);
    settle(16'h03E8, 16'h03E8);
    rd(8'h3C, 32'h00008000);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    final_report;
  end
  initial begin
    reset_n = 1'h0;
    {cyc, stb, we} = 3'h0;
    adr = 8'h00;
    wdat = 32'h0;
    info = 16'h0;
    qty = 48'h0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'h1;
    t_reset;
    t_timing;
    t_polarity;
    t_forced;
    t_scale;
    final_report;
  end
endmodule
